// File: core/irpf_pkg.sv
package irpf_pkg;
	// Register offsets (chosen, see note)
	localparam logic [3:0] IRPF_OFF_CTRL1 = 4'h0;
	localparam logic [3:0] IRPF_OFF_CTRL2 = 4'h1;
	localparam logic [3:0] IRPF_OFF_STAT = 4'h2;
	// Control one bit positions
	localparam int IRPF_C1_LOOP = 7;
	localparam int IRPF_C1_EN = 6;
	localparam int IRPF_C1_LEN9 = 4;
	localparam int IRPF_C1_WAKE = 3;
	localparam int IRPF_C1_IDLE_COUNT_TYPE = 2;
	localparam int IRPF_C1_PEN = 1;
	localparam int IRPF_C1_PTY = 0;
	// Control two bit positions
	localparam int IRPF_C2_TXEIE = 7;
	localparam int IRPF_C2_TX_DONE_IRQ_ENABLE = 6;
	localparam int IRPF_C2_RXFIE = 5;
	localparam int IRPF_C2_TE = 3;
	localparam int IRPF_C2_RE = 2;
	localparam logic [7:0] IRPF_C1_RESET = 8'h00;
	localparam logic [7:0] IRPF_C2_RESET = 8'h00;
	localparam logic [7:0] IRPF_C1_MASK = 8'hdf;
	localparam logic [7:0] IRPF_C2_MASK = 8'hec;
	// Frame lengths in bits
	localparam logic [3:0] IRPF_FRAME_SHORT = 4'ha;
	localparam logic [3:0] IRPF_FRAME_LONG = 4'hb;

	typedef struct packed {
		logic loop_sel;
		logic enable;
		logic len9;
		logic wake_addr;
		logic idle_after_stop;
		logic parity_en;
		logic parity_odd;
		logic ir_en;
		logic tx_en;
		logic rx_en;
		logic [3:0] frame_bits;
		logic [3:0] data_bits;
	} irpf_fmt_t;
endpackage

// File: core/irpf_pin_ctrl.sv
`timescale 1ns/1ps
module irpf_pin_ctrl
	import irpf_pkg::*;
(
	// Clock, reset and register bus
	input wire logic i_mclk,
	input wire logic i_reset_n,
	input wire logic [3:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [7:0] o_rdata,
	// Port, infrared and transmitter side
	input wire logic i_ir_en,
	input wire logic i_port_dir_tx,
	input wire logic i_port_out_tx,
	input wire logic i_port_dir_rx,
	input wire logic i_port_out_rx,
	input wire logic i_tx_serial,
	input wire logic i_tx_ir,
	input wire logic i_tx_busy,
	input wire logic i_tx_empty_flag,
	input wire logic i_tx_done_flag,
	input wire logic i_rx_full_flag,
	// Shared pins, open drain
	input wire logic i_tx_pin_in,
	output logic o_tx_pin_out,
	output logic o_tx_pin_oe_n,
	input wire logic i_rx_pin_in,
	output logic o_rx_pin_out,
	output logic o_rx_pin_oe_n,
	// To the port, the receiver and the shifters
	output logic o_port_tx_in,
	output logic o_port_rx_in,
	output logic o_rx_data,
	output logic o_baud_enable,
	output logic o_force_tx_flags,
	output logic o_preamble_start,
	output irpf_fmt_t o_fmt,
	output logic o_tx_irq,
	output logic o_rx_irq
);
	// Registers and their next values
	logic [7:0] ctrl1_q;
	logic [7:0] ctrl1_d;
	logic [7:0] ctrl2_q;
	logic [7:0] ctrl2_d;
	logic [7:0] rdata_q;
	logic [7:0] rdata_d;
	logic tx_en_q;
	logic tx_drive_q;
	logic tx_drive_d;
	logic parity_odd_q;
	logic parity_odd_d;
	logic [1:0] pin_meta_q;
	logic [1:0] pin_sync_q;

	// Decode and pin nets
	logic [7:0] status_word;
	logic [1:0] pin_raw;
	logic ctrl1_wr;
	logic ctrl2_wr;
	logic enable;
	logic tx_en;
	logic rx_en;
	logic loop_on;
	logic ir_on;
	logic tx_stream;
	logic tx_pull_low;
	logic port_tx_pull_low;
	logic port_rx_pull_low;
	logic rx_pin_level;
	logic tx_empty_req;
	logic tx_done_req;
	logic rx_full_req;
	logic [3:0] frame_bits;
	logic [3:0] data_bits;

	// Register strobes
	assign ctrl1_wr = i_wr && (i_addr == IRPF_OFF_CTRL1);
	assign ctrl2_wr = i_wr && (i_addr == IRPF_OFF_CTRL2);

	// Effective enables; transmitter and receiver drop with the module enable
	assign enable = ctrl1_q[IRPF_C1_EN];
	assign tx_en = enable & ctrl2_q[IRPF_C2_TE];
	assign rx_en = enable & ctrl2_q[IRPF_C2_RE];
	// Loop needs both directions on, so a half-enabled loop bit is inert
	assign loop_on = ctrl1_q[IRPF_C1_LOOP] & tx_en & rx_en;
	// The coder is never in the loop
	assign ir_on = i_ir_en & enable & ~loop_on;

	// Control one: plain write; bit five has no storage and reads zero
	always_comb begin
		ctrl1_d = ctrl1_q;
		if (ctrl1_wr) begin
			ctrl1_d = i_wdata & IRPF_C1_MASK;
		end
	end

	always_ff @(posedge i_mclk) begin
		if (!i_reset_n) begin
			ctrl1_q <= IRPF_C1_RESET;
		end else begin
			ctrl1_q <= ctrl1_d;
		end
	end

	// Control two: interrupt enables always take the write; the direction
	// enables only while the module is on, so software cannot start a
	// transmitter whose baud generator is stopped
	always_comb begin
		ctrl2_d = ctrl2_q;
		if (ctrl2_wr) begin
			ctrl2_d[7:4] = i_wdata[7:4] & IRPF_C2_MASK[7:4];
			ctrl2_d[1:0] = 2'h0;
			if (enable) begin
				ctrl2_d[3:2] = i_wdata[3:2];
			end
		end
	end

	always_ff @(posedge i_mclk) begin
		if (!i_reset_n) begin
			ctrl2_q <= IRPF_C2_RESET;
		end else begin
			ctrl2_q <= ctrl2_d;
		end
	end

	// Status view of the effective enables, so software can see the lock at work
	assign status_word = {4'h0, tx_drive_q, loop_on, rx_en, tx_en};

	// Read data stand in the following cycle only; reads have no side effects
	always_comb begin
		rdata_d = 8'h00;
		if (i_rd) begin
			case (i_addr)
				IRPF_OFF_CTRL1: begin
					rdata_d = ctrl1_q;
				end
				IRPF_OFF_CTRL2: begin
					rdata_d = ctrl2_q;
				end
				IRPF_OFF_STAT: begin
					rdata_d = status_word;
				end
				default: begin
					rdata_d = 8'h00;
				end
			endcase
		end
	end

	always_ff @(posedge i_mclk) begin
		if (!i_reset_n) begin
			rdata_q <= 8'h00;
		end else begin
			rdata_q <= rdata_d;
		end
	end
	assign o_rdata = rdata_q;

	// Rising edge of the effective transmitter enable kicks off the preamble;
	// a module disable drops the enable too, so re-enabling starts a fresh one
	always_ff @(posedge i_mclk) begin
		if (!i_reset_n) begin
			tx_en_q <= 1'b0;
		end else begin
			tx_en_q <= tx_en;
		end
	end
	assign o_preamble_start = tx_en & ~tx_en_q;

	// After TE clears the pin keeps driving until the character in flight has left, but a module disable cuts it
	// at once; cutting it early would chop the stop bit and hand the remote a framing error
	always_comb begin
		tx_drive_d = tx_drive_q;
		if (!enable) begin
			tx_drive_d = 1'b0;
		end else if (tx_en) begin
			tx_drive_d = 1'b1;
		end else if (!i_tx_busy) begin
			tx_drive_d = 1'b0;
		end
	end

	always_ff @(posedge i_mclk) begin
		if (!i_reset_n) begin
			tx_drive_q <= 1'b0;
		end else begin
			tx_drive_q <= tx_drive_d;
		end
	end

	// Parity sense handed on changes only between transmit characters, so a
	// careless mid-character write cannot spoil that character's parity
	always_comb begin
		parity_odd_d = parity_odd_q;
		if (!i_tx_busy) begin
			parity_odd_d = ctrl1_q[IRPF_C1_PTY];
		end
	end

	always_ff @(posedge i_mclk) begin
		if (!i_reset_n) begin
			parity_odd_q <= 1'b0;
		end else begin
			parity_odd_q <= parity_odd_d;
		end
	end

	// Pin synchronisers, one pair per pin; both reset to the idle-high level so
	// that no false start edge follows reset
	assign pin_raw = {i_rx_pin_in, i_tx_pin_in};
	for (genvar p = 0; p < 2; p++) begin : g_pin_sync
		always_ff @(posedge i_mclk) begin
			if (!i_reset_n) begin
				pin_meta_q[p] <= 1'b1;
				pin_sync_q[p] <= 1'b1;
			end else begin
				pin_meta_q[p] <= pin_raw[p];
				pin_sync_q[p] <= pin_meta_q[p];
			end
		end
	end
	assign o_port_tx_in = pin_sync_q[0];
	assign o_port_rx_in = pin_sync_q[1];
	assign rx_pin_level = pin_sync_q[1];

	// Coder output only when infrared is on and the loop is off
	always_comb begin
		if (ir_on) begin
			tx_stream = i_tx_ir;
		end else begin
			tx_stream = i_tx_serial;
		end
	end

	// Open-drain pins: pulled low only for a zero, a released pin idles high on
	// its pullup; the port direction bits are ignored while enabled
	assign tx_pull_low = tx_drive_q & ~tx_stream;
	assign port_tx_pull_low = i_port_dir_tx & ~i_port_out_tx;
	assign port_rx_pull_low = i_port_dir_rx & ~i_port_out_rx;

	// Transmit pin
	always_comb begin
		o_tx_pin_out = 1'b0;
		if (enable) begin
			o_tx_pin_oe_n = ~tx_pull_low;
		end else begin
			o_tx_pin_oe_n = ~port_tx_pull_low;
		end
	end

	// Receive pin is never driven while the block owns it
	always_comb begin
		o_rx_pin_out = 1'b0;
		if (enable) begin
			o_rx_pin_oe_n = 1'b1;
		end else begin
			o_rx_pin_oe_n = ~port_rx_pull_low;
		end
	end

	// Receiver sees idle-high when off, the loop when looped, else the pin
	always_comb begin
		if (!rx_en) begin
			o_rx_data = 1'b1;
		end else if (loop_on) begin
			o_rx_data = i_tx_serial;
		end else begin
			o_rx_data = rx_pin_level;
		end
	end

	// Baud generator runs only while enabled; the flag force holds both
	// transmit flags set for as long as the module is off
	assign o_baud_enable = enable;
	assign o_force_tx_flags = ~enable;

	// Frame length counts start and stop; parity steals one data bit
	assign frame_bits = ctrl1_q[IRPF_C1_LEN9] ? IRPF_FRAME_LONG : IRPF_FRAME_SHORT;
	assign data_bits = frame_bits - 4'h2 - {3'h0, ctrl1_q[IRPF_C1_PEN]};

	always_comb begin
		// Mode bits
		o_fmt.loop_sel = loop_on;
		o_fmt.enable = enable;
		o_fmt.len9 = ctrl1_q[IRPF_C1_LEN9];
		o_fmt.wake_addr = ctrl1_q[IRPF_C1_WAKE];
		o_fmt.idle_after_stop = ctrl1_q[IRPF_C1_IDLE_COUNT_TYPE];
		o_fmt.parity_en = ctrl1_q[IRPF_C1_PEN];
		o_fmt.parity_odd = parity_odd_q;

		// Effective enables
		o_fmt.ir_en = i_ir_en & enable;
		o_fmt.tx_en = tx_en;
		o_fmt.rx_en = rx_en;

		// Lengths
		o_fmt.frame_bits = frame_bits;
		o_fmt.data_bits = data_bits;
	end

	// Interrupt requests; transmitter ones blocked while disabled, the receiver
	// one is not, since a disable leaves the receive flag alone
	assign tx_empty_req = i_tx_empty_flag & ctrl2_q[IRPF_C2_TXEIE];
	assign tx_done_req = i_tx_done_flag & ctrl2_q[IRPF_C2_TX_DONE_IRQ_ENABLE];
	assign rx_full_req = i_rx_full_flag & ctrl2_q[IRPF_C2_RXFIE];

	always_comb begin
		o_tx_irq = 1'b0;
		if (enable) begin
			o_tx_irq = tx_empty_req | tx_done_req;
		end
	end
	assign o_rx_irq = rx_full_req;
endmodule

// File: dv/irpf_asserts.sv
`timescale 1ns/1ps
module irpf_asserts
	import irpf_pkg::*;
(
	input wire logic i_mclk,
	input wire logic i_reset_n,
	input wire logic i_ir_en,
	input wire logic i_tx_serial,
	input wire logic i_tx_ir,
	input wire logic i_tx_empty_flag,
	input wire logic i_tx_done_flag,
	input wire logic i_rx_full_flag,
	input wire logic o_tx_pin_oe_n,
	input wire logic o_rx_pin_oe_n,
	input wire logic o_rx_data,
	input wire logic o_baud_enable,
	input wire logic o_force_tx_flags,
	input wire logic o_preamble_start,
	input wire irpf_fmt_t o_fmt,
	input wire logic o_tx_irq,
	input wire logic o_rx_irq
);
	default clocking @(posedge i_mclk); endclocking
	default disable iff (!i_reset_n);
	a_baud_vs_force: assert property (o_baud_enable != o_force_tx_flags) else $error("baud and force agree");
	a_rx_pin_input: assert property (o_baud_enable |-> o_rx_pin_oe_n) else $error("rx pin driven");
	a_tx_stream_sel: assert property (o_fmt.tx_en && $past(o_fmt.tx_en) |->
		o_tx_pin_oe_n == ((i_ir_en && !o_fmt.loop_sel) ? i_tx_ir : i_tx_serial)) else $error("tx pin stream wrong");
	a_rx_ignored: assert property (!o_fmt.rx_en |-> o_rx_data) else $error("rx input not ignored");
	a_loop_route: assert property (o_fmt.loop_sel && o_fmt.tx_en && o_fmt.rx_en |->
		o_rx_data == i_tx_serial) else $error("loop route wrong");
	a_frame_len: assert property (o_fmt.frame_bits == (o_fmt.len9 ? 4'hb : 4'ha)) else $error("frame len");
	a_preamble_one: assert property (o_preamble_start |-> o_fmt.tx_en ##1 !o_preamble_start)
		else $error("preamble pulse wrong");
	a_tx_irq_src: assert property (o_tx_irq |-> o_baud_enable && (i_tx_empty_flag || i_tx_done_flag))
		else $error("tx irq without source");
	a_rx_irq_src: assert property (o_rx_irq |-> i_rx_full_flag) else $error("rx irq without flag");
	c_preamble: cover property (o_preamble_start);
	c_both_irq: cover property (o_tx_irq && o_rx_irq);
	c_loop: cover property (o_fmt.loop_sel && o_fmt.tx_en && o_fmt.rx_en);
endmodule
bind irpf_pin_ctrl irpf_asserts u_chk (.*);

// File: dv/irpf_remote.sv
`timescale 1ns/1ps
module irpf_remote #(parameter int BIT_CYC = 4) (
	input wire logic i_clk,
	input wire logic i_send,
	input wire logic [7:0] i_byte,
	output logic o_line
);
	logic [9:0] sh_q = 10'h3ff;
	int cnt_q = 0;
	assign o_line = sh_q[0]; // Idles high between frames
	always_ff @(posedge i_clk) begin
		if (i_send) begin
			sh_q <= {1'b1, i_byte, 1'b0};
			cnt_q <= 0;
		end else if (cnt_q == BIT_CYC - 1) begin
			sh_q <= {1'b1, sh_q[9:1]};
			cnt_q <= 0;
		end else begin
			cnt_q <= cnt_q + 1;
		end
	end
endmodule

// File: dv/tb_top.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin error_cnt++; $display("unexpected %s %h %h", n, e, g); end end
module tb_top;
	import irpf_pkg::*;
	logic i_mclk = 0, i_reset_n = 0, i_wr = 0, i_rd = 0, i_ir_en = 0, i_port_dir_tx = 0, i_port_out_tx = 1;
	logic i_port_dir_rx = 1, i_port_out_rx = 0, i_tx_serial = 1, i_tx_ir = 1, i_tx_busy = 0, send = 0;
	logic i_tx_empty_flag = 1, i_tx_done_flag = 0, i_rx_full_flag = 1;
	logic [3:0] i_addr = 4'h0;
	logic [7:0] i_wdata = 8'h00;
	logic [7:0] o_rdata;
	logic o_tx_pin_out, o_tx_pin_oe_n, o_rx_pin_out, o_rx_pin_oe_n, o_port_tx_in, o_port_rx_in, o_rx_data;
	logic o_baud_enable, o_force_tx_flags, o_preamble_start, o_tx_irq, o_rx_irq, line;
	irpf_fmt_t o_fmt;
	wire logic i_tx_pin_in = o_tx_pin_oe_n;
	wire logic i_rx_pin_in = line & o_rx_pin_oe_n;
	int error_cnt = 0, total_checks = 0, cyc = 0;
	irpf_pin_ctrl dut (.*);
	irpf_remote far (.i_clk(i_mclk), .i_send(send), .i_byte(8'h00), .o_line(line));
	initial forever #5 i_mclk = ~i_mclk;
	task automatic test_done();
		$display("checks %0d mismatches %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	always @(posedge i_mclk) begin
		cyc++;
		if (cyc == 3000) begin
			error_cnt++;
			test_done();
		end
	end
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		i_addr <= a;
		i_wdata <= d;
		i_wr <= 1'b1;
		@(posedge i_mclk);
		i_wr <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, input logic [7:0] e);
		i_addr <= a;
		i_rd <= 1'b1;
		@(posedge i_mclk);
		i_rd <= 1'b0;
		#1 `CHK("rdata", e, o_rdata)
		@(posedge i_mclk);
	endtask
	initial begin
		repeat (10) @(posedge i_mclk);
		i_reset_n <= 1'b1;
		@(posedge i_mclk);
		rd(IRPF_OFF_CTRL1, 8'h00);
		rd(IRPF_OFF_CTRL2, 8'h00);
		#1 `CHK("rxoe", 1'b0, o_rx_pin_oe_n)
		@(posedge i_mclk);
		wr(IRPF_OFF_CTRL2, 8'hec);
		rd(IRPF_OFF_CTRL2, 8'he0);
		rd(4'hf, 8'h00);
		$display("test regs done");
		for (int i = 0; i < 4; i++) begin
			wr(IRPF_OFF_CTRL1, {3'h2, i[1], 2'h0, i[0], 1'b0});
			#1 `CHK("dbits", 4'(8 + i[1] - i[0]), o_fmt.data_bits)
			`CHK("fbits", i[1] ? IRPF_FRAME_LONG : IRPF_FRAME_SHORT, o_fmt.frame_bits)
			@(posedge i_mclk);
		end
		wr(IRPF_OFF_CTRL2, 8'hec);
		#1 `CHK("pre", 1'b1, o_preamble_start)
		`CHK("irqs", 2'h3, {o_tx_irq, o_rx_irq})
		@(posedge i_mclk);
		wr(IRPF_OFF_CTRL1, 8'hff);
		rd(IRPF_OFF_CTRL1, 8'hdf);
		#1 `CHK("bits", 6'h3f, {o_fmt.loop_sel, o_fmt.len9, o_fmt.wake_addr, o_fmt.idle_after_stop,
			o_fmt.parity_en, o_fmt.parity_odd})
		i_tx_serial <= 1'b0;
		@(posedge i_mclk);
		#1 `CHK("loop", 1'b0, o_rx_data)
		`CHK("rxoe", 1'b1, o_rx_pin_oe_n)
		@(posedge i_mclk);
		wr(IRPF_OFF_CTRL2, 8'h4c);
		#1 `CHK("txirq", 1'b0, o_tx_irq)
		i_tx_done_flag <= 1'b1;
		i_tx_busy <= 1'b1;
		@(posedge i_mclk);
		#1 `CHK("txirq", 1'b1, o_tx_irq)
		@(posedge i_mclk);
		wr(IRPF_OFF_CTRL2, 8'h44);
		#1 `CHK("txoe", 1'b0, o_tx_pin_oe_n)
		i_tx_busy <= 1'b0;
		repeat (3) @(posedge i_mclk);
		#1 `CHK("txoe", 1'b1, o_tx_pin_oe_n)
		@(posedge i_mclk);
		$display("test pins done");
		wr(IRPF_OFF_CTRL1, 8'h40);
		send <= 1'b1;
		@(posedge i_mclk);
		send <= 1'b0;
		repeat (6) @(posedge i_mclk);
		#1 `CHK("rxin", 1'b0, o_rx_data)
		`CHK("portrx", 1'b0, o_port_rx_in)
		@(posedge i_mclk);
		wr(IRPF_OFF_CTRL2, 8'h4c);
		i_ir_en <= 1'b1;
		i_tx_ir <= 1'b0;
		i_tx_serial <= 1'b1;
		@(posedge i_mclk);
		#1 `CHK("irpin", 1'b0, o_tx_pin_oe_n)
		`CHK("irfmt", 1'b1, o_fmt.ir_en)
		@(posedge i_mclk);
		rd(IRPF_OFF_STAT, 8'h0b);
		@(posedge i_mclk);
		wr(IRPF_OFF_CTRL1, 8'h00);
		#1 `CHK("force", 1'b1, o_force_tx_flags)
		`CHK("txirq", 1'b0, o_tx_irq)
		`CHK("txport", 1'b1, o_tx_pin_oe_n)
		`CHK("pinout", 2'h0, {o_tx_pin_out, o_rx_pin_out})
		$display("test frame done");
		test_done();
	end
endmodule
